//--- design/event_timer.v
// Gated 16-bit event timer with an AHB-Lite register slave.
// Assumes one 100 MHz clock, a synchronous active-high reset, and that pins
// and comparator outputs are asynchronous while the trigger and timer0
// overflow come from logic on the same clock.
// Contract
// - Special event trigger clears the whole count
// - Trigger clear never sets overflow flag
// - Compare interrupt still possible on trigger
// - Compare pair acts as period via trigger
// - Count byte write beats simultaneous trigger
// - External rising edge counts after a falling
// - Source field picks sensing, pin, system, instruction
// - Oscillator enable picks crystal over pin
// - Prescale field divides by 1, 2, 4, 8
// - Sync bit matters only for external sources
// - On bit runs counter; off clears toggle
// - Gate enable ignored off; else gate controls
// - Polarity picks high or low counting gate
// - Toggle mode flip-flop; clear disables and resets
// - Single-pulse bit hands gate to acquisition
// - Go/done shows armed; cleared when mode off
// - Gate level bit shows live gate state
// - Gate source field picks pin, timer0, comparators
// - Count wraps to zero and sets overflow
// - Armed pulse opens on edge, closes trailing
// - Gate level falling edge sets gate flag
// - Count on prescaled tick while gate permits
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_defs.vh"

module event_timer (
    input wire clock,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire external_clock_pin,
    input wire crystal_in_pin,
    output reg crystal_out_pin,
    input wire sensing_oscillator,
    input wire gate_pin,
    input wire timer0_overflow,
    input wire comparator_one_output,
    input wire comparator_two_output,
    input wire special_event_trigger,
    output reg compare_event,
    output reg overflow_flag,
    output reg gate_event_flag,
    output reg [15:0] count_value
);

    // Synchronised asynchronous inputs: pin clock, crystal, sensing osc, gate pin, cmp1, cmp2
    reg [5:0] sync1_reg; // First stage, read only by the second
    reg [5:0] sync2_reg; // Second stage, safe to use
    reg [5:0] sync3_reg; // Extra stage used when resynchronising to the system clock
    // Software registers
    reg [7:0] timer_control_reg;
    reg [7:0] gate_control_reg; // Bit 2 is not stored, it reads the live gate
    reg [15:0] count_reg;
    // Clock path state
    reg [1:0] instr_div_reg; // Instruction clock divider
    reg [2:0] prescale_reg; // Prescaler count
    reg ext_prev_reg; // Previous external source level for edge detection
    reg fall_seen_reg; // A falling edge has been seen since enable
    // Gate path state
    reg gate_src_prev_reg; // Previous selected gate source level
    reg toggle_reg; // Toggle mode flip-flop
    reg gate_active_prev_reg; // Previous gate level after polarity
    reg pulse_window_reg; // Single-pulse window is open
    reg gate_level_reg; // Registered gate level value
    // Bus address phase capture
    reg wr_pending_reg;
    reg [7:0] wr_addr_reg;

    // Combinational signals
    reg ext_src; // Selected external clock level
    reg src_tick; // One-cycle pulse from the selected source
    reg [2:0] ps_last; // Last prescaler count before a tick
    reg gate_src; // Selected gate source
    reg [7:0] read_mux; // Register read value
    wire [5:0] async_in;
    wire [1:0] clk_src;
    wire external_sel;
    wire prescale_tick;
    wire gate_src_rise;
    wire gate_after_toggle;
    wire gate_active;
    wire gate_active_rise;
    wire gate_active_fall;
    wire gate_level_next;
    wire count_permit;
    wire addr_phase;
    wire wr_ctrl;
    wire wr_gate;
    wire wr_low;
    wire wr_high;
    wire wr_flags;
    wire ext_rise;
    wire ext_fall;
    wire [5:0] sync_sel;

    assign async_in = {comparator_two_output, comparator_one_output, gate_pin,
                       sensing_oscillator, crystal_in_pin, external_clock_pin};
    assign clk_src = timer_control_reg[`TC_SRC_HI:`TC_SRC_LO];
    assign external_sel = clk_src[1];
    // Bypass uses the two-flop copy, sync mode adds a system clock stage
    assign sync_sel = timer_control_reg[`TC_SYNC_BYP] ? sync2_reg : sync3_reg;

    // Two-flop synchronisers plus an optional resync stage
    always @(posedge clock) begin
        if (rst) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            sync3_reg <= 6'h00;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // External source choice: sensing oscillator, crystal or clock pin
    always @* begin
        if (clk_src == `SRC_SENSE) begin
            ext_src = external_sel ? sync_sel[2] : sync2_reg[2];
        end else if (timer_control_reg[`TC_OSC_EN]) begin
            ext_src = sync_sel[1];
        end else begin
            ext_src = sync_sel[0];
        end
    end

    assign ext_rise = ext_src & ~ext_prev_reg;
    assign ext_fall = ~ext_src & ext_prev_reg;

    // Source tick: instruction rate from the divider, system every cycle, external rates from edges
    always @* begin
        case (clk_src)
            `SRC_INSTR: src_tick = (instr_div_reg == `INSTR_DIV_LAST);
            `SRC_SYSTEM: src_tick = 1'b1;
            `SRC_PIN: src_tick = ext_rise & fall_seen_reg;
            `SRC_SENSE: src_tick = ext_rise & fall_seen_reg;
            default: src_tick = 1'b0;
        endcase
    end

    // Prescale ratio decode
    always @* begin
        case (timer_control_reg[`TC_PS_HI:`TC_PS_LO])
            2'h0: ps_last = 3'h0;
            2'h1: ps_last = 3'h1;
            2'h2: ps_last = 3'h3;
            2'h3: ps_last = 3'h7;
            default: ps_last = 3'h0;
        endcase
    end

    assign prescale_tick = src_tick & (prescale_reg == ps_last);

    // Divider, prescaler and external edge history
    always @(posedge clock) begin
        if (rst) begin
            instr_div_reg <= 2'h0;
            prescale_reg <= 3'h0;
            ext_prev_reg <= 1'b0;
            fall_seen_reg <= 1'b0;
        end else begin
            instr_div_reg <= instr_div_reg + 2'h1;
            ext_prev_reg <= ext_src;
            // Forget the falling edge while off so the first rise after enable is ignored
            if (!timer_control_reg[`TC_ON]) begin
                fall_seen_reg <= 1'b0;
            end else if (ext_fall) begin
                fall_seen_reg <= 1'b1;
            end
            // Prescaler restarts when stopped or when the count is written
            if (!timer_control_reg[`TC_ON] || wr_low || wr_high) begin
                prescale_reg <= 3'h0;
            end else if (prescale_tick) begin
                prescale_reg <= 3'h0;
            end else if (src_tick) begin
                prescale_reg <= prescale_reg + 3'h1;
            end
        end
    end

    // Gate source selection
    always @* begin
        case (gate_control_reg[`GC_SS_HI:`GC_SS_LO])
            `GSS_PIN: gate_src = sync2_reg[3];
            `GSS_T0_OVF: gate_src = timer0_overflow;
            `GSS_CMP1: gate_src = sync2_reg[4];
            `GSS_CMP2: gate_src = sync2_reg[5];
            default: gate_src = 1'b0;
        endcase
    end

    assign gate_src_rise = gate_src & ~gate_src_prev_reg;
    assign gate_after_toggle = gate_control_reg[`GC_TOGGLE] ? toggle_reg : gate_src;
    assign gate_active = gate_control_reg[`GC_POL] ? gate_after_toggle : ~gate_after_toggle;
    assign gate_active_rise = gate_active & ~gate_active_prev_reg;
    assign gate_active_fall = ~gate_active & gate_active_prev_reg;
    // In single-pulse mode the armed window, and the cycle of every active rise even unarmed, reaches the counter
    assign gate_level_next = gate_control_reg[`GC_SPM] ?
                             (gate_active & (pulse_window_reg | gate_active_rise)) :
                             gate_active;
    assign count_permit = timer_control_reg[`TC_ON] &
                          (~gate_control_reg[`GC_ENABLE] | gate_level_reg);

    // Gate toggle, single-pulse window and gate level
    always @(posedge clock) begin
        if (rst) begin
            gate_src_prev_reg <= 1'b0;
            toggle_reg <= 1'b0;
            gate_active_prev_reg <= 1'b0;
            pulse_window_reg <= 1'b0;
            gate_level_reg <= 1'b0;
        end else begin
            gate_src_prev_reg <= gate_src;
            gate_active_prev_reg <= gate_active;
            gate_level_reg <= gate_level_next;
            // Toggle held clear when mode is off or timer is stopped
            if (!gate_control_reg[`GC_TOGGLE] || !timer_control_reg[`TC_ON]) begin
                toggle_reg <= 1'b0;
            end else if (gate_src_rise) begin
                toggle_reg <= ~toggle_reg;
            end
            // Window opens on the first active edge once armed and shuts on the trailing edge
            if (!gate_control_reg[`GC_SPM]) begin
                pulse_window_reg <= 1'b0;
            end else if (pulse_window_reg && gate_active_fall) begin
                pulse_window_reg <= 1'b0;
            end else if (gate_control_reg[`GC_GO] && gate_active_rise) begin
                pulse_window_reg <= 1'b1;
            end
        end
    end

    // AHB-Lite address phase and write decode
    assign addr_phase = hsel & hready & htrans[`HTRANS_ACTIVE];
    assign wr_ctrl = wr_pending_reg & (wr_addr_reg == `OFS_TIMER_CONTROL);
    assign wr_gate = wr_pending_reg & (wr_addr_reg == `OFS_GATE_CONTROL);
    assign wr_low = wr_pending_reg & (wr_addr_reg == `OFS_COUNT_LOW);
    assign wr_high = wr_pending_reg & (wr_addr_reg == `OFS_COUNT_HIGH);
    assign wr_flags = wr_pending_reg & (wr_addr_reg == `OFS_FLAGS);

    // Read value for the addressed register; unmapped addresses read zero
    always @* begin
        case (haddr[7:0])
            `OFS_TIMER_CONTROL: read_mux = timer_control_reg & `TC_WRITE_MASK;
            `OFS_GATE_CONTROL: read_mux = {gate_control_reg[7:3], gate_level_reg,
                                           gate_control_reg[1:0]};
            `OFS_COUNT_LOW: read_mux = count_reg[7:0];
            `OFS_COUNT_HIGH: read_mux = count_reg[15:8];
            `OFS_FLAGS: read_mux = {6'h00, gate_event_flag, overflow_flag};
            default: read_mux = 8'h00;
        endcase
    end

    // Bus slave: zero wait states, always OKAY, read data launched at the address edge
    always @(posedge clock) begin
        if (rst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pending_reg <= addr_phase & hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_phase && !hwrite) begin
                hrdata <= {24'h000000, read_mux};
            end
        end
    end

    // Control registers
    always @(posedge clock) begin
        if (rst) begin
            timer_control_reg <= `TIMER_CONTROL_RST;
            gate_control_reg <= `GATE_CONTROL_RST;
        end else begin
            if (wr_ctrl) begin
                timer_control_reg <= hwdata[7:0] & `TC_WRITE_MASK;
            end
            if (wr_gate) begin
                gate_control_reg[7:4] <= hwdata[7:4];
                gate_control_reg[1:0] <= hwdata[1:0];
            end
            gate_control_reg[2] <= 1'b0;
            // Go/done: dropped when mode is off, else software arms it and the trailing edge ends it
            if (wr_gate && !hwdata[`GC_SPM]) begin
                gate_control_reg[`GC_GO] <= 1'b0;
            end else if (!gate_control_reg[`GC_SPM] && !wr_gate) begin
                gate_control_reg[`GC_GO] <= 1'b0;
            end else if (wr_gate) begin
                gate_control_reg[`GC_GO] <= hwdata[`GC_GO];
            end else if (pulse_window_reg && gate_active_fall) begin
                gate_control_reg[`GC_GO] <= 1'b0;
            end
        end
    end

    // Counter: byte write first, then trigger clear, then increment
    always @(posedge clock) begin
        if (rst) begin
            count_reg <= 16'h0000;
        end else if (wr_low || wr_high) begin
            // A write in the trigger cycle keeps the written byte
            if (wr_low) begin
                count_reg[7:0] <= hwdata[7:0];
            end
            if (wr_high) begin
                count_reg[15:8] <= hwdata[7:0];
            end
        end else if (special_event_trigger) begin
            count_reg <= 16'h0000;
        end else if (prescale_tick && count_permit) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Sticky flags and outputs; a set in the clear cycle wins
    always @(posedge clock) begin
        if (rst) begin
            overflow_flag <= 1'b0;
            gate_event_flag <= 1'b0;
            compare_event <= 1'b0;
            count_value <= 16'h0000;
            crystal_out_pin <= 1'b0;
        end else begin
            overflow_flag <= (overflow_flag & ~(wr_flags & hwdata[`FL_OVERFLOW])) |
                             (~wr_low & ~wr_high & ~special_event_trigger & prescale_tick &
                              count_permit & (count_reg == 16'hFFFF));
            gate_event_flag <= (gate_event_flag & ~(wr_flags & hwdata[`FL_GATE_EVENT])) |
                               (gate_level_reg & ~gate_level_next);
            compare_event <= special_event_trigger;
            count_value <= count_reg;
            // Crystal driver inverts the input only while the oscillator is enabled
            crystal_out_pin <= timer_control_reg[`TC_OSC_EN] & ~sync2_reg[1];
        end
    end

endmodule // event_timer
`default_nettype wire

//--- design/event_timer_defs.vh
// Constants for the gated 16-bit event timer: register offsets, field positions,
// reset values and divider counts.
// Assumes it is included by its bare name from the timer module only.
`ifndef EVENT_TIMER_DEFS_VH
`define EVENT_TIMER_DEFS_VH

// Register byte offsets on the bus
`define OFS_TIMER_CONTROL 8'h00
`define OFS_GATE_CONTROL 8'h04
`define OFS_COUNT_LOW 8'h08
`define OFS_COUNT_HIGH 8'h0C
`define OFS_FLAGS 8'h10

// Timer control fields
`define TC_SRC_HI 7
`define TC_SRC_LO 6
`define TC_PS_HI 5
`define TC_PS_LO 4
`define TC_OSC_EN 3
`define TC_SYNC_BYP 2
`define TC_ON 0
`define TC_WRITE_MASK 8'hFD

// Gate control fields
`define GC_ENABLE 7
`define GC_POL 6
`define GC_TOGGLE 5
`define GC_SPM 4
`define GC_GO 3
`define GC_VALUE 2
`define GC_SS_HI 1
`define GC_SS_LO 0

// Flag register fields, write one to clear
`define FL_OVERFLOW 0
`define FL_GATE_EVENT 1

// Clock source codes
`define SRC_INSTR 2'h0
`define SRC_SYSTEM 2'h1
`define SRC_PIN 2'h2
`define SRC_SENSE 2'h3

// Gate source codes
`define GSS_PIN 2'h0
`define GSS_T0_OVF 2'h1
`define GSS_CMP1 2'h2
`define GSS_CMP2 2'h3

// Reset values
`define TIMER_CONTROL_RST 8'h00
`define GATE_CONTROL_RST 8'h00

// Instruction clock is the system clock divided by four
`define INSTR_DIV_LAST 2'h3

// AHB transfer type bit that marks NONSEQ or SEQ
`define HTRANS_ACTIVE 1

`endif

//--- testbench/event_timer_monitor.sv
// Checker for the event timer, watching only its top-level ports.
// Assumes a zero-wait bus slave and a count copy one cycle late.
`timescale 1ns/1ps
`default_nettype none
module event_timer_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic special_event_trigger,
    input wire logic compare_event,
    input wire logic overflow_flag,
    input wire logic [15:0] count_value
);
    wire take = hsel && hready && htrans[1]; // Transfer taken at this edge
    reg cnt_wr_reg; // Count byte write in its data phase
    reg low_wr_reg; // Low byte write in its data phase
    reg ctl_wr_reg; // Control write in its data phase
    reg ctl_rd_reg; // Control read data on the bus
    reg gate_rd_reg; // Gate control read data on the bus
    reg on_reg; // Shadow of the on bit, so no peeking inside
    // Track bus phases
    always @(posedge clock) begin
        if (rst) begin
            cnt_wr_reg <= 1'b0;
            low_wr_reg <= 1'b0;
            ctl_wr_reg <= 1'b0;
            ctl_rd_reg <= 1'b0;
            gate_rd_reg <= 1'b0;
            on_reg <= 1'b0;
        end else begin
            cnt_wr_reg <= take && hwrite && (haddr[7:0] == 8'h08 || haddr[7:0] == 8'h0C);
            low_wr_reg <= take && hwrite && haddr[7:0] == 8'h08;
            ctl_wr_reg <= take && hwrite && haddr[7:0] == 8'h00;
            ctl_rd_reg <= take && !hwrite && haddr[7:0] == 8'h00;
            gate_rd_reg <= take && !hwrite && haddr[7:0] == 8'h04;
            on_reg <= ctl_wr_reg ? hwdata[0] : on_reg;
        end
    end
    AST_TRIG_CLEAR: assert property (@(posedge clock) disable iff (rst)
        special_event_trigger && !cnt_wr_reg |-> ##2 count_value == 16'h0000)
        else $error("count not cleared by trigger");
    AST_TRIG_NO_OVF: assert property (@(posedge clock) disable iff (rst)
        !overflow_flag && special_event_trigger |=> !overflow_flag)
        else $error("trigger set overflow flag");
    AST_CMP_EVENT: assert property (@(posedge clock) disable iff (rst)
        special_event_trigger |=> compare_event)
        else $error("compare event missing");
    AST_WRITE_WINS: assert property (@(posedge clock) disable iff (rst)
        low_wr_reg && special_event_trigger |-> ##2 count_value[7:0] == $past(hwdata[7:0], 2))
        else $error("write lost to trigger");
    AST_OFF_HOLDS: assert property (@(posedge clock) disable iff (rst)
        !on_reg && !cnt_wr_reg && !special_event_trigger |-> ##2 $stable(count_value))
        else $error("count moved while off");
    AST_GO_IDLE: assert property (@(posedge clock) disable iff (rst)
        gate_rd_reg && !hrdata[4] |-> !hrdata[3])
        else $error("go bit set without single pulse mode");
    AST_WRAP: assert property (@(posedge clock) disable iff (rst)
        $rose(overflow_flag) |-> count_value == 16'hFFFF ##1 count_value == 16'h0000)
        else $error("overflow without wrap");
    AST_BIT1_ZERO: assert property (@(posedge clock) disable iff (rst)
        ctl_rd_reg |-> hrdata[1] == 1'b0 && hrdata[31:8] == 24'h000000)
        else $error("control unused bits not zero");
endmodule // event_timer_monitor
bind event_timer event_timer_monitor mon (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .special_event_trigger(special_event_trigger),
    .compare_event(compare_event), .overflow_flag(overflow_flag), .count_value(count_value));
`default_nettype wire

//--- testbench/gated_16bit_event_timer_test.sv
// Bench for the event timer: bus tasks and scenario sequences.
// Assumes design, checker and far side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gated_16bit_event_timer_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic gate_req = 1'b0; // Level on the selected gate line
    logic [1:0] gsel = 2'h0; // Selected line; the others carry the inverse
    logic fire = 1'b0; // Forced trigger
    logic match_en = 1'b0;
    logic [15:0] period = 16'h0000;
    wire hready;
    wire compare_event;
    wire overflow_flag;
    wire [31:0] hrdata;
    wire [15:0] count_value;
    wire ext_clk;
    wire trig;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int i;
    logic [15:0] c;
    logic [15:0] top;
    logic [31:0] q;
    logic seen;
    event_timer dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(), .hrdata(hrdata), .external_clock_pin(ext_clk), .crystal_in_pin(ext_clk),
        .crystal_out_pin(), .sensing_oscillator(ext_clk),
        .gate_pin(gsel == 2'h0 ? gate_req : !gate_req),
        .timer0_overflow(gsel == 2'h1 ? gate_req : !gate_req),
        .comparator_one_output(gsel == 2'h2 ? gate_req : !gate_req),
        .comparator_two_output(gsel == 2'h3 ? gate_req : !gate_req),
        .special_event_trigger(trig), .compare_event(compare_event),
        .overflow_flag(overflow_flag), .gate_event_flag(), .count_value(count_value));
    timer_far_side far (.clock(clock), .rst(rst), .count_value(count_value), .period(period),
        .match_enable(match_en), .fire_now(fire), .special_event_trigger(trig),
        .ext_clock(ext_clk));
    initial begin
        forever #5 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    task finish_test;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One single transfer; hready and read data are taken at rising edges
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic f, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        fire <= f;
        do begin
            @(posedge clock);
            r = hrdata;
        end while (hready !== 1'b1);
        fire <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b0, q);
    endtask
    task automatic rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
        tests_run++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t value %h outside %h..%h", $time, g, lo, hi);
        end
    endtask
    // Masked register read, upper bits must be zero
    task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b0, q);
        rng({15'h0000, (q & {24'hFFFFFF, m}) === {24'h000000, e}}, 16'h0001, 16'h0001);
    endtask
    // Count read with the timer stopped, so no tearing
    task automatic get_count();
        bus(1'b0, 8'h08, 8'h00, 1'b0, q);
        c[7:0] = q[7:0];
        bus(1'b0, 8'h0C, 8'h00, 1'b0, q);
        c[15:8] = q[7:0];
    endtask
    // Optionally clear, run n cycles with ctl, stop and read
    task automatic run(input logic [7:0] ctl, input int n, input logic z);
        if (z) begin
            wr(8'h08, 8'h00);
            wr(8'h0C, 8'h00);
        end
        wr(8'h00, ctl);
        repeat (n) @(posedge clock);
        wr(8'h00, 8'h00);
        get_count();
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk(8'h00, 8'hFF, 8'h00);
        chk(8'h04, 8'hFB, 8'h00);
        wr(8'h00, 8'hFE);
        chk(8'h00, 8'hFF, 8'hFC);
        wr(8'h20, 8'hFF);
        chk(8'h20, 8'hFF, 8'h00);
        // Internal sources: 64 enabled cycles per run
        for (i = 0; i < 5; i++) begin
            run(i < 4 ? {2'h1, i[1:0], 4'h1} : 8'h01, 62, 1'b1);
            top = i < 4 ? 16'd64 >> i : 16'd16;
            rng(c, top - 16'd1, top + 16'd1);
        end
        // External sources: five pulses, the first rise is not counted
        for (i = 0; i < 4; i++) begin
            top = {8'h00, i == 3 ? 2'h3 : 2'h2, 2'h0, i == 1, i == 2, 2'h1};
            run(8'h00, 0, 1'b1);
            wr(8'h00, top[7:0]);
            far.send_pulses(5, i == 2 ? 3 : 8);
            run(top[7:0], 12, 1'b0);
            rng(c, 16'd4, 16'd4);
        end
        wr(8'h08, 8'hFD);
        wr(8'h0C, 8'hFF);
        run(8'h41, 6, 1'b0);
        rng(c, 16'h0004, 16'h0006);
        chk(8'h10, 8'h01, 8'h01);
        wr(8'h10, 8'h01);
        chk(8'h10, 8'h01, 8'h00);
        // Gate: blocked then passing, each polarity and source
        for (i = 0; i < 8; i++) begin
            gsel <= i[1:0];
            gate_req <= !i[2];
            wr(8'h04, {1'b1, i[2], 4'h0, i[1:0]});
            repeat (8) @(posedge clock);
            chk(8'h04, 8'h04, 8'h00);
            run(8'h41, 20, 1'b1);
            rng(c, 16'd0, 16'd0);
            gate_req <= i[2];
            repeat (8) @(posedge clock);
            chk(8'h04, 8'h04, 8'h04);
            run(8'h41, 20, 1'b1);
            rng(c, 16'd21, 16'd23);
            gate_req <= !i[2];
            repeat (8) @(posedge clock);
            chk(8'h10, 8'h02, 8'h02);
            wr(8'h10, 8'h02);
        end
        // Compare pair as period, on the system clock in step with the trigger
        period <= 16'h0010;
        match_en <= 1'b1;
        top = 16'h0000;
        seen = 1'b0;
        wr(8'h04, 8'h00); // Gate off, the loop above left it closed
        run(8'h00, 0, 1'b1);
        wr(8'h00, 8'h41);
        repeat (100) begin
            @(negedge clock);
            top = count_value > top ? count_value : top;
            seen = seen | compare_event;
        end
        @(posedge clock);
        period <= 16'hFFFE;
        wr(8'h00, 8'h00);
        // Trigger lands on the FFFF to 0000 step and must not raise overflow
        wr(8'h08, 8'hF8);
        wr(8'h0C, 8'hFF);
        run(8'h41, 10, 1'b0);
        match_en <= 1'b0;
        rng(top, 16'h0011, 16'h0011);
        rng({15'h0000, seen}, 16'h0001, 16'h0001);
        chk(8'h10, 8'h01, 8'h00);
        bus(1'b1, 8'h08, 8'h5A, 1'b1, q);
        get_count();
        rng(c, 16'h005A, 16'h005A);
        bus(1'b1, 8'h20, 8'h00, 1'b1, q);
        get_count();
        rng(c, 16'h0000, 16'h0000);
        // Single pulse: the first gate pulse counts, the second only for its rising cycle
        gsel <= 2'h0;
        gate_req <= 1'b0;
        wr(8'h04, 8'hD0);
        wr(8'h04, 8'hD8);
        chk(8'h04, 8'h08, 8'h08);
        run(8'h00, 0, 1'b1);
        wr(8'h00, 8'h41);
        for (i = 0; i < 2; i++) begin
            repeat (10) @(posedge clock);
            gate_req <= 1'b1;
            repeat (20) @(posedge clock);
            gate_req <= 1'b0;
            repeat (10) @(posedge clock);
            chk(8'h04, 8'h08, 8'h00);
        end
        run(8'h41, 0, 1'b0);
        rng(c, 16'd19, 16'd21);
        wr(8'h04, 8'hD8);
        wr(8'h04, 8'hC8);
        chk(8'h04, 8'h08, 8'h00);
        // Toggle: one gate pulse leaves the gate open until switched off
        wr(8'h00, 8'h41);
        wr(8'h04, 8'hE0);
        gate_req <= 1'b1;
        repeat (10) @(posedge clock);
        gate_req <= 1'b0;
        repeat (10) @(posedge clock);
        chk(8'h04, 8'h04, 8'h04);
        wr(8'h00, 8'h00);
        repeat (6) @(posedge clock);
        chk(8'h04, 8'h04, 8'h00);
        finish_test();
    end
endmodule // gated_16bit_event_timer_test
`default_nettype wire

//--- testbench/timer_far_side.sv
// Far side model: compare unit with trigger, and an external clock source.
// Assumes the bench steers period, match enable and forced fire.
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] count_value,
    input wire logic [15:0] period,
    input wire logic match_enable,
    input wire logic fire_now,
    output logic special_event_trigger,
    output var logic ext_clock
);
    // Fire on a match with the compare pair, or when forced
    assign special_event_trigger = !rst && (fire_now || (match_enable && count_value == period));
    // Clock rests low between bursts
    initial begin
        ext_clock = 1'b0;
    end
    // Burst of n pulses; half sets prompt or slow edges
    task automatic send_pulses(input int n, input int half);
        for (int k = 0; k < n; k++) begin
            repeat (half) @(posedge clock);
            ext_clock <= 1'b1;
            repeat (half) @(posedge clock);
            ext_clock <= 1'b0;
        end
    endtask
endmodule // timer_far_side
`default_nettype wire
